// File: logic/oms_defs.svh
// Constants of the operating-mode supervisor: timing counts, field positions, reset values.
// Assumes a 125 MHz system clock on both ends.
`ifndef OMS_DEFS_SVH
`define OMS_DEFS_SVH

`define OMS_CLK_MHZ        125
`define OMS_UV_TIME_US     2000
`define OMS_FAIL_TIME_US   4000
`define OMS_SU_TIME_US     100000
`define OMS_WD_SHORT_US    100000
`define OMS_WD_LONG_US     200000
`define OMS_UV_CYC         (`OMS_UV_TIME_US * `OMS_CLK_MHZ)
`define OMS_FAIL_CYC       (`OMS_FAIL_TIME_US * `OMS_CLK_MHZ)
`define OMS_SU_CYC         (`OMS_SU_TIME_US * `OMS_CLK_MHZ)
`define OMS_WD_SHORT_CYC   (`OMS_WD_SHORT_US * `OMS_CLK_MHZ)
`define OMS_WD_LONG_CYC    (`OMS_WD_LONG_US * `OMS_CLK_MHZ)
`define OMS_WD_MAX_FAILS   2'h3
`define OMS_CNT_W          25

// Status word bit positions
`define OMS_ST_FAILSAFE    0
`define OMS_ST_WDOG_FLT    1
`define OMS_ST_UV_TO       2
`define OMS_ST_STUCK       3
`define OMS_ST_SHORT       4
`define OMS_ST_FAIL        5
`define OMS_ST_OT          6
`define OMS_ST_SOFT        7
`define OMS_ST_RESET       8
`define OMS_ST_W           9
// Status after power-on reset: only the reset bit is set
`define OMS_ST_RESET_VAL   9'h100

// Control word: bit 0 soft limp request, bit 1 short window, bit 2 trigger
`define OMS_CTL_SOFT       0
`define OMS_CTL_WD_SHORT   1
`define OMS_CTL_TRIG       2
`define OMS_CTL_W          3
`define OMS_CTL_RESET      3'h0

`endif

// File: logic/oms_host.sv
// Host end: drives the control word, toggles the watchdog trigger, clears status.
// Assumes the device end samples ctl_data on ctl_write in the same cycle.
`timescale 1ns/10ps
`include "oms_defs.svh"
module oms_host (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Link to device
    oms_link_if.host                   link,
    // User side
    input  wire logic                  kick,
    input  wire logic                  set_soft_limp,
    input  wire logic                  clr_soft_limp,
    input  wire logic                  sel_short_window,
    input  wire logic                  clear_status,
    output logic [`OMS_ST_W-1:0]       status_seen
);
    import oms_pkg::*;

    // ==========================================================
    logic trig_r;
    logic soft_r;
    logic wr_r;
    logic clr_r;
    logic [`OMS_CTL_W-1:0] ctl_out_r;

    wire soft_nxt = set_soft_limp ? 1'b1 : (clr_soft_limp ? 1'b0 : soft_r);
    wire any_wr   = kick || set_soft_limp || clr_soft_limp;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_r      <= 1'b0;
            soft_r      <= 1'b0;
            wr_r        <= 1'b0;
            clr_r       <= 1'b0;
            ctl_out_r   <= `OMS_CTL_RESET;
            status_seen <= '0;
        end else begin
            trig_r      <= kick ? !trig_r : trig_r;
            soft_r      <= soft_nxt;
            wr_r        <= any_wr;
            clr_r       <= clear_status;
            ctl_out_r   <= {kick ? !trig_r : trig_r, sel_short_window, soft_nxt};
            status_seen <= link.status;
        end
    end

    assign link.ctl_data          = ctl_out_r;
    assign link.ctl_write         = wr_r;
    assign link.status_read_clear = clr_r;
endmodule : oms_host

// File: logic/oms_link_if.sv
// Link between the supervisor and its host: control write strobe, status reply.
// Assumes both ends run on one clock.
`timescale 1ns/10ps
`include "oms_defs.svh"
interface oms_link_if;
    logic [`OMS_CTL_W-1:0] ctl_data;
    logic                  ctl_write;
    logic                  status_read_clear;
    logic [`OMS_ST_W-1:0]  status;
    modport dev  (input ctl_data, input ctl_write, input status_read_clear, output status);
    modport host (output ctl_data, output ctl_write, output status_read_clear, input status);
endinterface : oms_link_if

// File: logic/oms_pkg.sv
// Types shared by both ends of the operating-mode supervisor.
// Assumes oms_defs.svh is available on the include path.
package oms_pkg;
    typedef enum logic [2:0] {
        OMS_STARTUP,
        OMS_STARTUP_FAIL,
        OMS_NORMAL,
        OMS_SOFT_LIMP,
        OMS_LIMP
    } oms_mode_t;
endpackage : oms_pkg

// File: logic/oms_supervisor.sv
// Device end: operating-mode supervisor of the LED converter controller.
// Assumes analog comparators arrive as synchronous levels on clk.
`timescale 1ns/10ps
`include "oms_defs.svh"
module oms_supervisor #(
    parameter int UV_CYC       = `OMS_UV_CYC,
    parameter int FAIL_CYC     = `OMS_FAIL_CYC,
    parameter int SU_CYC       = `OMS_SU_CYC,
    parameter int WD_SHORT_CYC = `OMS_WD_SHORT_CYC,
    parameter int WD_LONG_CYC  = `OMS_WD_LONG_CYC
) (
    // Clock and reset (rst is power-on reset or enable toggle)
    input  wire logic         clk,
    input  wire logic         rst,
    // Link to host
    oms_link_if.dev           link,
    // Configuration and supply monitors
    input  wire logic         host_present,
    input  wire logic         battery_above_min,
    input  wire logic         reg1_above_reset,
    input  wire logic         reg1_above_fail,
    input  wire logic         reg1_overtemp,
    input  wire logic         serial_stuck,
    // Converter control
    input  wire logic         dim_logic_in,
    input  wire logic         limp_drive_pin,
    output logic              converter_on,
    output logic              reg1_enable,
    output oms_pkg::oms_mode_t mode
);
    import oms_pkg::*;

    // ==========================================================
    // State
    oms_mode_t              mode_r, mode_nxt;
    logic                   host_r;
    logic                   cfg_done_r;
    logic [`OMS_CTL_W-1:0]  ctl_r, ctl_nxt;
    logic                   trig_seen_r;
    logic [`OMS_ST_W-1:0]   st_r, st_nxt;
    logic                   reg1_on_r, reg1_on_nxt;
    logic [1:0]             wd_fails_r, wd_fails_nxt;
    logic [`OMS_CNT_W-1:0]  uv_cnt_r, fail_cnt_r, su_cnt_r, wd_cnt_r;

    // ==========================================================
    // Decode
    wire host_eff  = cfg_done_r ? host_r : host_present;
    wire wr_soft   = link.ctl_write && link.ctl_data[`OMS_CTL_SOFT];
    wire trig_flip = link.ctl_write && (link.ctl_data[`OMS_CTL_TRIG] != trig_seen_r);
    wire uv_now    = !reg1_above_reset;
    wire fail_now  = !reg1_above_fail;
    wire [`OMS_CNT_W-1:0] wd_limit = ctl_r[`OMS_CTL_WD_SHORT] ? `OMS_CNT_W'(WD_SHORT_CYC - 1)
                                                              : `OMS_CNT_W'(WD_LONG_CYC - 1);
    wire uv_exp    = uv_cnt_r == `OMS_CNT_W'(UV_CYC);
    wire fail_exp  = fail_cnt_r == `OMS_CNT_W'(FAIL_CYC);
    wire su_exp    = su_cnt_r == `OMS_CNT_W'(SU_CYC);
    wire wd_exp    = host_eff && (mode_r != OMS_STARTUP) && (wd_cnt_r == wd_limit);
    wire cause_clr = link.status_read_clear;
    // Taken from the registered word so the exit decision does not loop back into itself
    wire causes_left = !cause_clr && (|st_r[`OMS_ST_OT:`OMS_ST_WDOG_FLT]);

    // ==========================================================
    // Latch of host or standalone, taken once after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_r     <= 1'b0;
            cfg_done_r <= 1'b0;
        end else if (!cfg_done_r) begin
            host_r     <= host_present;
            cfg_done_r <= 1'b1;
        end
    end

    // ==========================================================
    // Fault duration counters, restart when the condition goes away
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uv_cnt_r   <= '0;
            fail_cnt_r <= '0;
            su_cnt_r   <= '0;
        end else begin
            uv_cnt_r   <= (uv_now && mode_r == OMS_NORMAL && !uv_exp) ? uv_cnt_r + 1'b1
                        : (uv_now && uv_exp) ? uv_cnt_r : '0;
            fail_cnt_r <= (fail_now && mode_r == OMS_STARTUP && !fail_exp) ? fail_cnt_r + 1'b1
                        : (fail_now && fail_exp) ? fail_cnt_r : '0;
            su_cnt_r   <= (uv_now && battery_above_min && mode_r == OMS_STARTUP && !su_exp)
                        ? su_cnt_r + 1'b1
                        : (uv_now && battery_above_min && su_exp) ? su_cnt_r : '0;
        end
    end

    // Watchdog window counter; restarted by a trigger toggle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_cnt_r    <= '0;
            trig_seen_r <= 1'b0;
        end else begin
            if (link.ctl_write)
                trig_seen_r <= link.ctl_data[`OMS_CTL_TRIG];
            wd_cnt_r <= (trig_flip || wd_exp || mode_r == OMS_STARTUP) ? '0 : wd_cnt_r + 1'b1;
        end
    end

    // ==========================================================
    // Mode, control word, status and regulator enable
    always_comb begin
        mode_nxt     = mode_r;
        ctl_nxt      = link.ctl_write ? link.ctl_data : ctl_r;
        st_nxt       = st_r;
        reg1_on_nxt  = reg1_on_r;
        wd_fails_nxt = trig_flip ? 2'h0 : wd_fails_r;
        if (cause_clr)
            st_nxt[`OMS_ST_RESET:`OMS_ST_WDOG_FLT] = '0;
        st_nxt[`OMS_ST_SOFT] = (mode_r == OMS_SOFT_LIMP);

        unique case (mode_r)
            OMS_STARTUP: begin
                if (!host_eff)
                    mode_nxt = OMS_NORMAL;
                else if (reg1_above_reset && reg1_above_fail)
                    mode_nxt = OMS_NORMAL;
                else if (!battery_above_min && uv_now) begin
                    mode_nxt    = OMS_STARTUP_FAIL;
                    reg1_on_nxt = 1'b0;
                end else if (fail_exp) begin
                    mode_nxt = OMS_LIMP;
                    st_nxt[`OMS_ST_SHORT] = 1'b1;
                    st_nxt[`OMS_ST_FAIL]  = 1'b1;
                    reg1_on_nxt = 1'b0;
                end else if (su_exp) begin
                    mode_nxt = OMS_LIMP;
                    st_nxt[`OMS_ST_SHORT] = 1'b1;
                    reg1_on_nxt = 1'b0;
                end
            end
            OMS_STARTUP_FAIL: ;
            OMS_NORMAL: begin
                if (host_eff) begin
                    if (ctl_nxt[`OMS_CTL_SOFT] && wr_soft)
                        mode_nxt = OMS_SOFT_LIMP;
                    else if (wd_exp) begin
                        mode_nxt = OMS_LIMP;
                        st_nxt[`OMS_ST_WDOG_FLT] = 1'b1;
                        wd_fails_nxt = wd_fails_r + 2'h1;
                    end else if (uv_exp) begin
                        mode_nxt = OMS_LIMP;
                        st_nxt[`OMS_ST_UV_TO] = 1'b1;
                    end else if (serial_stuck) begin
                        mode_nxt = OMS_LIMP;
                        st_nxt[`OMS_ST_STUCK] = 1'b1;
                    end
                end
            end
            OMS_SOFT_LIMP: begin
                if (!ctl_r[`OMS_CTL_SOFT] && trig_flip)
                    mode_nxt = OMS_NORMAL;
            end
            OMS_LIMP: begin
                if (wd_exp) begin
                    st_nxt[`OMS_ST_WDOG_FLT] = 1'b1;
                    wd_fails_nxt = (wd_fails_r == `OMS_WD_MAX_FAILS) ? wd_fails_r : wd_fails_r + 2'h1;
                    if (wd_fails_nxt == `OMS_WD_MAX_FAILS)
                        reg1_on_nxt = 1'b0;
                end
                if (trig_flip && !causes_left && !wd_exp && !reg1_overtemp && !serial_stuck) begin
                    mode_nxt    = OMS_NORMAL;
                    reg1_on_nxt = 1'b1;
                    wd_fails_nxt = 2'h0;
                end
            end
        endcase

        // Overtemperature wins in every state when a host is present; standalone it only drops the regulator
        if (reg1_overtemp && host_eff) begin
            mode_nxt    = OMS_LIMP;
            reg1_on_nxt = 1'b0;
            st_nxt[`OMS_ST_OT] = 1'b1;
        end else if (reg1_overtemp && !host_eff) begin
            reg1_on_nxt = 1'b0;
        end

        // Entering a limp mode restores defaults but keeps the request bit
        if ((mode_nxt == OMS_LIMP || mode_nxt == OMS_SOFT_LIMP) && mode_nxt != mode_r) begin
            ctl_nxt = `OMS_CTL_RESET;
            ctl_nxt[`OMS_CTL_SOFT] = (mode_nxt == OMS_SOFT_LIMP) ? 1'b1 : ctl_r[`OMS_CTL_SOFT];
        end
        st_nxt[`OMS_ST_FAILSAFE] = (mode_nxt == OMS_LIMP) || (mode_nxt == OMS_SOFT_LIMP);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r     <= OMS_STARTUP;
            ctl_r      <= `OMS_CTL_RESET;
            st_r       <= `OMS_ST_RESET_VAL;
            reg1_on_r  <= 1'b1;
            wd_fails_r <= 2'h0;
        end else begin
            mode_r     <= mode_nxt;
            ctl_r      <= ctl_nxt;
            st_r       <= st_nxt;
            reg1_on_r  <= reg1_on_nxt;
            wd_fails_r <= wd_fails_nxt;
        end
    end

    // ==========================================================
    // Outputs; reset bit reports the power-on reset after start-up
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            converter_on <= 1'b0;
        else
            unique case (mode_r)
                OMS_STARTUP:      converter_on <= 1'b0;
                OMS_STARTUP_FAIL: converter_on <= battery_above_min && dim_logic_in;
                OMS_NORMAL:       converter_on <= dim_logic_in;
                OMS_SOFT_LIMP:    converter_on <= limp_drive_pin;
                OMS_LIMP:         converter_on <= limp_drive_pin;
            endcase
    end

    assign reg1_enable = reg1_on_r;
    assign mode        = mode_r;
    assign link.status = st_r;
endmodule : oms_supervisor

// File: testbench/oms_link_asserts.sv
// Checker on the supervisor link: status flags and host strobes.
// Assumes one clock; instantiated in tb_top beside the link interface.
`timescale 1ns/10ps
`include "oms_defs.svh"
module oms_link_asserts (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // Link signals
    input wire logic [`OMS_CTL_W-1:0] ctl_data,
    input wire logic                  ctl_write,
    input wire logic                  status_read_clear,
    input wire logic [`OMS_ST_W-1:0]  status
);
    // Last soft limp request written by the host
    logic soft_req_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            soft_req_r <= 1'b0;
        end else if (ctl_write) begin
            soft_req_r <= ctl_data[`OMS_CTL_SOFT];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================
    // Assertions
    reset_reply_a: assert property ($fell(rst) |-> status == `OMS_ST_RESET_VAL)
        else $error("status after reset lacks the reset bit");
    reset_bit_clr_a: assert property (status_read_clear |=> !status[`OMS_ST_RESET])
        else $error("reset status bit survived clear");
    write_strobe_a: assert property (ctl_write |=> !ctl_write)
        else $error("write strobe longer than one cycle");
    clear_strobe_a: assert property (status_read_clear |=> !status_read_clear)
        else $error("clear strobe longer than one cycle");
    cause_sticky_a: assert property (!status_read_clear |=>
        (status[6:1] & $past(status[6:1])) == $past(status[6:1]))
        else $error("cause bit dropped without clear");
    wd_cleared_a: assert property (status_read_clear |=> !status[`OMS_ST_WDOG_FLT])
        else $error("watchdog fault bit survived clear");
    fault_failsafe_a: assert property ($rose(status[1] | status[3]) |-> ##[0:2] status[0])
        else $error("fault without failsafe bit");
    soft_rise_a: assert property ($rose(status[`OMS_ST_SOFT]) |-> soft_req_r)
        else $error("soft limp flag without request");
    soft_fall_a: assert property ($fell(status[`OMS_ST_SOFT]) |-> !soft_req_r)
        else $error("soft limp flag left while requested");

    wd_fault_c: cover property ($rose(status[`OMS_ST_WDOG_FLT]));
    soft_limp_c: cover property ($rose(status[`OMS_ST_SOFT]));
    recovery_c: cover property (status_read_clear ##[1:300] !status[`OMS_ST_FAILSAFE]);
endmodule : oms_link_asserts

// File: testbench/tb_top.sv
// Bench joining supervisor and host through the link, checker beside it.
// Assumes shortened fault and watchdog counts given by parameter.
`timescale 1ns/10ps
`include "oms_defs.svh"
module tb_top;
    import oms_pkg::*;
    // Input bits: host, battery ok, above reset, above fail, overtemp, stuck, dim, limp pin
    localparam int HP = 0, BAT = 1, RUV = 2, RFL = 3, OT = 4, STK = 5, DIM = 6, LPIN = 7;
    localparam int SSET = 0, SCLR = 1, SHORT = 2, CLR = 3;
    logic                 clk      = 1'b0;
    logic                 rst      = 1'b1;
    logic                 kick_on  = 1'b0;
    logic                 kick_req = 1'b0;
    logic [7:0]           ins      = 8'h0e;
    logic [3:0]           req      = 4'h0;
    logic                 converter_on;
    logic                 reg1_enable;
    oms_mode_t            mode;
    logic [`OMS_ST_W-1:0] status_seen;
    int                   n_errors = 0;
    int                   compares = 0;
    int                   k;

    oms_link_if link ();
    oms_supervisor #(.UV_CYC(20), .FAIL_CYC(40), .SU_CYC(100), .WD_SHORT_CYC(300), .WD_LONG_CYC(600))
        oms_supervisor_inst (.clk(clk), .rst(rst), .link(link), .host_present(ins[HP]),
        .battery_above_min(ins[BAT]), .reg1_above_reset(ins[RUV]), .reg1_above_fail(ins[RFL]),
        .reg1_overtemp(ins[OT]), .serial_stuck(ins[STK]), .dim_logic_in(ins[DIM]),
        .limp_drive_pin(ins[LPIN]), .converter_on(converter_on), .reg1_enable(reg1_enable), .mode(mode));
    oms_host oms_host_inst (.clk(clk), .rst(rst), .link(link), .kick(kick_req), .set_soft_limp(req[SSET]),
        .clr_soft_limp(req[SCLR]), .sel_short_window(req[SHORT]), .clear_status(req[CLR]),
        .status_seen(status_seen));
    oms_link_asserts oms_link_asserts_inst (.clk(clk), .rst(rst), .ctl_data(link.ctl_data),
        .ctl_write(link.ctl_write), .status_read_clear(link.status_read_clear), .status(link.status));

    initial begin
        forever #4 clk = ~clk;
    end

    // One process owns the trigger request, so scenarios never fight over it
    initial begin
        forever begin
            repeat (100) @(posedge clk);
            kick_req <= kick_on;
            @(posedge clk);
            kick_req <= 1'b0;
        end
    end

    // ==========================================
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic drive(input int i, input logic v, input int n);
        @(posedge clk);
        ins[i] <= v;
        repeat (n) @(posedge clk);
        #1;
    endtask : drive

    task automatic strobe(input int i);
        @(posedge clk);
        req[i] <= 1'b1;
        @(posedge clk);
        req[i] <= 1'b0;
    endtask : strobe

    task automatic wait_mode(input oms_mode_t m, input int lim);
        for (k = 0; k < lim && mode !== m; k++) drive(LPIN, ins[LPIN], 0);
        check(mode, m);
        if (mode !== m) print_verdict();
    endtask : wait_mode

    task automatic do_reset(input logic [7:0] v);
        @(posedge clk);
        rst     <= 1'b1;
        kick_on <= 1'b0;
        ins     <= v;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    // Clear first, then let the background trigger land
    task automatic recover(input int b);
        strobe(CLR);
        kick_on <= 1'b1;
        wait_mode(OMS_NORMAL, 300);
        drive(LPIN, 1'b0, 3);
        check({status_seen[b], status_seen[`OMS_ST_FAILSAFE]}, 2'h0);
    endtask : recover

    task automatic fault(input int i, input int b, input logic r1);
        drive(i, !ins[i], 0);
        wait_mode(OMS_LIMP, 60);
        drive(i, !ins[i], 3);
        check(reg1_enable, r1);
        check(status_seen[b], 1'b1);
        recover(b);
    endtask : fault

    // ==========================================
    // Scenarios
    task automatic s_startup();
        do_reset(8'h09);
        wait_mode(OMS_STARTUP_FAIL, 200);
        check(reg1_enable, 1'b0);
        drive(DIM, 1'b1, 3);
        check(converter_on, 1'b0);
        drive(BAT, 1'b1, 3);
        check(converter_on, 1'b1);
        do_reset(8'h03);
        wait_mode(OMS_LIMP, 60);
        check(k > 38 && k < 50, 1'b1);
        do_reset(8'h0b);
        wait_mode(OMS_LIMP, 150);
        check(k > 98 && k < 110, 1'b1);
        do_reset(8'h02);
        wait_mode(OMS_NORMAL, 200);
        drive(DIM, 1'b1, 700);
        check({mode, converter_on}, {OMS_NORMAL, 1'b1});
    endtask : s_startup

    task automatic s_watchdog();
        do_reset(8'h0f);
        kick_on <= 1'b1;
        wait_mode(OMS_NORMAL, 50);
        drive(HP, 1'b0, 700);
        check(mode, OMS_NORMAL);
        drive(DIM, 1'b1, 3);
        check(converter_on, 1'b1);
        kick_on <= 1'b0;
        wait_mode(OMS_LIMP, 800);
        check(k > 480 && k < 620, 1'b1);
        drive(LPIN, 1'b1, 3);
        check(converter_on, 1'b1);
        check(status_seen[1:0], 2'h3);
        drive(LPIN, 1'b0, 3);
        check(converter_on, 1'b0);
        recover(`OMS_ST_WDOG_FLT);
        @(posedge clk);
        req[SHORT] <= 1'b1;
        repeat (250) @(posedge clk);
        kick_on <= 1'b0;
        wait_mode(OMS_LIMP, 400);
        check(k > 180 && k < 320, 1'b1);
        check(reg1_enable, 1'b1);
        for (k = 0; k < 1400 && reg1_enable !== 1'b0; k++) drive(LPIN, 1'b0, 0);
        check(k > 550 && k < 1250, 1'b1);
        recover(`OMS_ST_WDOG_FLT);
    endtask : s_watchdog

    task automatic s_faults();
        repeat (2) begin
            drive(RUV, 1'b0, 14);
            drive(RUV, 1'b1, 2);
        end
        check(mode, OMS_NORMAL);
        fault(RUV, `OMS_ST_UV_TO, 1'b1);
        fault(STK, `OMS_ST_STUCK, 1'b1);
        fault(OT, `OMS_ST_OT, 1'b0);
        strobe(SSET);
        wait_mode(OMS_SOFT_LIMP, 20);
        // Short window and trigger bits were written high; only the request bit may survive
        check(oms_supervisor_inst.ctl_r, `OMS_CTL_RESET | (3'h1 << `OMS_CTL_SOFT));
        drive(LPIN, 1'b1, 3);
        check({converter_on, status_seen[`OMS_ST_SOFT]}, 2'h3);
        drive(LPIN, 1'b0, 3);
        check(converter_on, 1'b0);
        strobe(SCLR);
        wait_mode(OMS_NORMAL, 300);
        drive(LPIN, 1'b0, 3);
        check({status_seen[`OMS_ST_SOFT], status_seen[`OMS_ST_FAILSAFE]}, 2'h0);
    endtask : s_faults

    initial begin
        s_startup();
        s_watchdog();
        s_faults();
        drive(STK, 1'b1, 0);
        wait_mode(OMS_LIMP, 60);
        do_reset(8'h0f);
        kick_on <= 1'b1;
        wait_mode(OMS_NORMAL, 50);
        check(status_seen[`OMS_ST_RESET], 1'b1);
        print_verdict();
    end
endmodule : tb_top
